// file: verilog/csp_regs.svh
// Register offsets, field positions, reset values and counts for the
// card socket power control block.
// Assumes byte addresses on an 8-bit Wishbone address, 32-bit data.
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// Register byte offsets
`define CSP_SOCKET_CTRL_ADDR 8'h10
`define CSP_CARD_TYPE_ADDR 8'h14

// Socket voltage control fields
`define CSP_VPP_LSB 0
`define CSP_VCC_LSB 4
`define CSP_POLICY_BIT 7
`define CSP_ONE_BIT 10
`define CSP_CTRL_RESET 32'h00000000

// Card type control fields
`define CSP_WAKE_EN_BIT 0
`define CSP_REFUSED_BIT 1
`define CSP_PWR_EN_BIT 2
`define CSP_TYPE_LSB 10
`define CSP_RETEST_BIT 14

// Idle clocks before the card clock may be stopped
`define CSP_IDLE_CLOCKS 8

`endif

// file: verilog/csp_pkg.sv
// Types and voltage code decoding for the card socket power control block.
// Assumes nothing beyond a SystemVerilog compiler.
package csp_pkg;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } csp_wb_req_type;

  // Clock stop gate states
  typedef enum logic {CSP_CLK_RUN, CSP_CLK_STOP_OK} csp_stop_state_type;

  // State of the clock stop gate
  typedef struct packed {
    csp_stop_state_type state;
    logic [4:0] idle_cnt;
  } csp_stop_type;

  // State of the socket power control register bank
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [2:0] vcc_req;
    logic [2:0] vpp_req;
    logic stop_policy;
    logic wake_en;
    logic [3:0] card_type;
    logic pwr_ctrl_en;
    logic refused;
    logic [2:0] vcc_out;
    logic [2:0] vpp_out;
  } csp_ctrl_type;

  // True for a code that names a voltage or power off
  function automatic logic csp_code_legal(input logic [2:0] code,
                                          input logic is_vpp);
    csp_code_legal = (code == 3'h0) || (is_vpp && code == 3'h1) ||
                     (code >= 3'h2 && code <= 3'h5);
  endfunction

  // True when the card accepts the coded voltage; card type is
  // {y.y, x.x, 3.3, 5}; 12 V programming voltage is always accepted
  function automatic logic csp_code_ok(input logic [2:0] code,
                                       input logic is_vpp,
                                       input logic [3:0] ctype);
    case (code)
      3'h0: csp_code_ok = 1'b1;
      3'h1: csp_code_ok = is_vpp;
      3'h2: csp_code_ok = ctype[0];
      3'h3: csp_code_ok = ctype[1];
      3'h4: csp_code_ok = ctype[2];
      3'h5: csp_code_ok = ctype[3];
      default: csp_code_ok = 1'b0;
    endcase
  endfunction

endpackage

// file: verilog/csp_clock_stop.sv
// Clock stop gate: decides when the card clock may be stopped or slowed.
// Assumes idle and clock-run inputs synchronous to clk_i.
`include "csp_regs.svh"
module csp_clock_stop
  import csp_pkg::*;
#(
  parameter int IDLE_CLOCKS = `CSP_IDLE_CLOCKS
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Policy and conditions
  input wire logic stop_policy_i,
  input wire logic socket_idle_i,
  input wire logic pci_stop_prep_i,
  // Permission to stop the card clock
  output logic stop_ok_o
);

  localparam logic [4:0] IDLE_MAX = 5'(IDLE_CLOCKS);

  // Refuse counts the counter cannot hold
  if (IDLE_CLOCKS < 1 || IDLE_CLOCKS > 31)
  begin : g_bad
    $error("csp_clock_stop: IDLE_CLOCKS out of range");
  end

  csp_stop_type s_reg;
  csp_stop_type s_next;

  // Count idle clocks and apply the stop policy
  always_comb
  begin
    s_next = s_reg;
    if (!socket_idle_i)
      s_next.idle_cnt = 5'h00;
    else if (s_reg.idle_cnt < IDLE_MAX)
      s_next.idle_cnt = s_reg.idle_cnt + 5'h01;
    if (s_next.idle_cnt >= IDLE_MAX &&
        (stop_policy_i || pci_stop_prep_i))
      s_next.state = CSP_CLK_STOP_OK;
    else
      s_next.state = CSP_CLK_RUN;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_reg <= '{state: CSP_CLK_RUN, idle_cnt: 5'h00};
    else
      s_reg <= s_next;
  end

  assign stop_ok_o = (s_reg.state == CSP_CLK_STOP_OK);

  // With the policy clear, clock held unless the PCI clock is being stopped too
  property p_needs_pci;
    @(posedge clk_i) disable iff (rst_i)
    !stop_policy_i && !pci_stop_prep_i |=> !stop_ok_o;
  endproperty
  a_needs_pci: assert property (p_needs_pci)
    else $error("card clock stop allowed without PCI stop");

  // Idleness alone is enough under the set policy
  property p_idle_alone;
    @(posedge clk_i) disable iff (rst_i)
    (socket_idle_i && stop_policy_i)[*8] |=> stop_ok_o;
  endproperty
  a_idle_alone: assert property (p_idle_alone)
    else $error("card clock stop not allowed after idle period");

  // Activity withdraws permission at once
  property p_busy;
    @(posedge clk_i) disable iff (rst_i)
    !socket_idle_i |=> !stop_ok_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("card clock stop allowed while socket busy");

  // Permission seen
  c_stop: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(stop_ok_o));

endmodule

// file: verilog/csp_socket_power.sv
// Socket voltage control register bank with a classic Wishbone slave.
// Assumes a power switch that follows the applied voltage codes and a
// card type sense that is stable when a retest is written.
//
// Overview of operation
// - Control bits 31-11 and 9-8 read zero; writes to them are lost.
// - Control bit 10 always reads one.
// - Control bit 3 between the voltage fields reads zero.
// - Policy clear: stop card clock after 8 idle clocks and PCI stop.
// - Policy set: stop card clock on socket idleness alone.
// - Supply code: 000 off, 010 5V, 011 3.3V, 100 X, 101 Y.
// - Program code: 000 off, 001 12V, 010 5V, 011 3.3V, 100, 101.
// - Socket powered only at voltages the card accepts.
// - With wake enabled only global reset clears voltage requests.
// - With wake disabled bus or global reset clears voltage requests.
// - Retest reloads card type and re-enables power control.
`include "csp_regs.svh"
module csp_socket_power
  import csp_pkg::*;
#(
  parameter int IDLE_CLOCKS = `CSP_IDLE_CLOCKS
)
(
  // Clock and global reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire csp_wb_req_type wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Socket side inputs
  input wire logic bus_reset_in_i,
  input wire logic [3:0] card_type_i,
  input wire logic socket_idle_i,
  input wire logic pci_stop_prep_i,
  // Power switch and clock control
  output logic [2:0] vcc_sel_o,
  output logic [2:0] vpp_sel_o,
  output logic card_clock_stop_ok_o
);

  // Refuse counts the clock stop gate cannot hold
  if (IDLE_CLOCKS < 1 || IDLE_CLOCKS > 31)
  begin : g_bad
    $error("csp_socket_power: IDLE_CLOCKS out of range");
  end

  csp_ctrl_type s_reg;
  csp_ctrl_type s_next;
  logic take;
  logic wr_ctrl;
  logic wr_type;

  // Control register image as software reads it
  function automatic logic [31:0] ctrl_image(input csp_ctrl_type s);
    logic [31:0] v;
    v = 32'h00000000;
    v[`CSP_ONE_BIT] = 1'b1;
    v[`CSP_POLICY_BIT] = s.stop_policy;
    v[`CSP_VCC_LSB +: 3] = s.vcc_req;
    v[`CSP_VPP_LSB +: 3] = s.vpp_req;
    return v;
  endfunction

  // Card type register image as software reads it
  function automatic logic [31:0] type_image(input csp_ctrl_type s);
    logic [31:0] v;
    v = 32'h00000000;
    v[`CSP_TYPE_LSB +: 4] = s.card_type;
    v[`CSP_PWR_EN_BIT] = s.pwr_ctrl_en;
    v[`CSP_REFUSED_BIT] = s.refused;
    v[`CSP_WAKE_EN_BIT] = s.wake_en;
    return v;
  endfunction

  // Bus request taken on the edge that raises ack
  assign take = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
  assign wr_ctrl = take && wb_req_i.we &&
                   wb_req_i.adr == `CSP_SOCKET_CTRL_ADDR;
  assign wr_type = take && wb_req_i.we &&
                   wb_req_i.adr == `CSP_CARD_TYPE_ADDR;

  // Next state: bus access, resets, power switch control
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = take;
    s_next.rdata = 32'h00000000;
    if (take && !wb_req_i.we)
    begin
      if (wb_req_i.adr == `CSP_SOCKET_CTRL_ADDR)
        s_next.rdata = ctrl_image(s_reg);
      else if (wb_req_i.adr == `CSP_CARD_TYPE_ADDR)
        s_next.rdata = type_image(s_reg);
    end
    // Only the low byte of the control register holds bits
    if (wr_ctrl && wb_req_i.sel[0])
    begin
      s_next.stop_policy = wb_req_i.dat[`CSP_POLICY_BIT];
      s_next.vcc_req = wb_req_i.dat[`CSP_VCC_LSB +: 3];
      s_next.vpp_req = wb_req_i.dat[`CSP_VPP_LSB +: 3];
    end
    if (wr_type && wb_req_i.sel[0])
    begin
      s_next.wake_en = wb_req_i.dat[`CSP_WAKE_EN_BIT];
      if (wb_req_i.dat[`CSP_REFUSED_BIT])
        s_next.refused = 1'b0;
    end
    if (wr_type && wb_req_i.sel[1])
    begin
      if (wb_req_i.dat[`CSP_RETEST_BIT])
      begin
        s_next.card_type = card_type_i;
        s_next.pwr_ctrl_en = 1'b1;
      end
      else
      begin
        s_next.card_type = wb_req_i.dat[`CSP_TYPE_LSB +: 4];
        if (|wb_req_i.dat[`CSP_TYPE_LSB +: 4])
          s_next.pwr_ctrl_en = 1'b0;
      end
    end
    // Bus reset clears requests only while wake signalling is off
    if (bus_reset_in_i && !s_reg.wake_en)
    begin
      s_next.vcc_req = 3'h0;
      s_next.vpp_req = 3'h0;
    end
    // Supply switch follows only legal, accepted requests
    if (s_reg.pwr_ctrl_en && csp_code_legal(s_reg.vcc_req, 1'b0))
    begin
      if (csp_code_ok(s_reg.vcc_req, 1'b0, s_reg.card_type))
        s_next.vcc_out = s_reg.vcc_req;
      else
        s_next.refused = 1'b1;
    end
    // Programming switch follows only legal, accepted requests
    if (s_reg.pwr_ctrl_en && csp_code_legal(s_reg.vpp_req, 1'b1))
    begin
      if (csp_code_ok(s_reg.vpp_req, 1'b1, s_reg.card_type))
        s_next.vpp_out = s_reg.vpp_req;
      else
        s_next.refused = 1'b1;
    end
  end

  // State register; rst_i is the global reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      s_reg.pwr_ctrl_en <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // Clock stop gate
  csp_clock_stop #(
    .IDLE_CLOCKS(IDLE_CLOCKS)
  ) u_clock_stop (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .stop_policy_i(s_reg.stop_policy),
    .socket_idle_i(socket_idle_i),
    .pci_stop_prep_i(pci_stop_prep_i),
    .stop_ok_o(card_clock_stop_ok_o)
  );

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign vcc_sel_o = s_reg.vcc_out;
  assign vpp_sel_o = s_reg.vpp_out;

  // Read of the control register shows fixed reserved bits
  property p_rsvd_zero;
    @(posedge clk_i) disable iff (rst_i)
    $past(wr_ctrl == 1'b0 && take && !wb_req_i.we &&
          wb_req_i.adr == `CSP_SOCKET_CTRL_ADDR)
    |-> wb_ack_o && wb_dat_o[31:11] == 21'h000000 &&
        wb_dat_o[9:8] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved control bits not zero");

  property p_one_bit;
    @(posedge clk_i) disable iff (rst_i)
    $past(take && !wb_req_i.we && wb_req_i.adr == `CSP_SOCKET_CTRL_ADDR)
    |-> wb_dat_o[10];
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("control bit 10 not one");

  property p_gap_bit;
    @(posedge clk_i) disable iff (rst_i)
    $past(take && !wb_req_i.we && wb_req_i.adr == `CSP_SOCKET_CTRL_ADDR)
    |-> !wb_dat_o[3] &&
        wb_dat_o[6:4] == $past(s_reg.vcc_req);
  endproperty
  a_gap_bit: assert property (p_gap_bit)
    else $error("control bit 3 not zero or supply field wrong");

  // Global reset leaves power off requested and policy clear
  property p_reset;
    @(posedge clk_i)
    rst_i |=> s_reg.vcc_req == 3'h0 && s_reg.vpp_req == 3'h0 &&
              !s_reg.stop_policy && vcc_sel_o == 3'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset values wrong");

  // Wake enabled: bus reset does not touch requests
  property p_wake_hold;
    @(posedge clk_i) disable iff (rst_i)
    bus_reset_in_i && s_reg.wake_en && !wr_ctrl
    |=> s_reg.vcc_req == $past(s_reg.vcc_req) &&
        s_reg.vpp_req == $past(s_reg.vpp_req);
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("bus reset cleared wake context bits");

  property p_bus_clear;
    @(posedge clk_i) disable iff (rst_i)
    bus_reset_in_i && !s_reg.wake_en
    |=> s_reg.vcc_req == 3'h0 && s_reg.vpp_req == 3'h0;
  endproperty
  a_bus_clear: assert property (p_bus_clear)
    else $error("bus reset failed to clear voltage requests");

  // Switch never moves to a voltage the card refuses
  property p_accept;
    @(posedge clk_i) disable iff (rst_i)
    !csp_code_ok(s_reg.vcc_req, 1'b0, s_reg.card_type)
    |=> vcc_sel_o == $past(vcc_sel_o);
  endproperty
  a_accept: assert property (p_accept)
    else $error("socket powered at unaccepted voltage");

  // Programming switch never moves to a voltage the card refuses
  property p_accept_vpp;
    @(posedge clk_i) disable iff (rst_i)
    !csp_code_ok(s_reg.vpp_req, 1'b1, s_reg.card_type)
    |=> vpp_sel_o == $past(vpp_sel_o);
  endproperty
  a_accept_vpp: assert property (p_accept_vpp)
    else $error("programming rail set to unaccepted voltage");

  // Unaccepted legal request raises the flag, even against a clear
  property p_refuse_flag;
    @(posedge clk_i) disable iff (rst_i)
    s_reg.pwr_ctrl_en && csp_code_legal(s_reg.vcc_req, 1'b0) &&
    !csp_code_ok(s_reg.vcc_req, 1'b0, s_reg.card_type)
    |=> s_reg.refused;
  endproperty
  a_refuse_flag: assert property (p_refuse_flag)
    else $error("refused flag not raised for unaccepted request");

  // Reserved programming codes never reach the programming switch
  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
    !csp_code_legal(s_reg.vpp_req, 1'b1)
    |=> vpp_sel_o == $past(vpp_sel_o);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved programming code changed the switch");

  // Accepted supply request is applied one clock later
  property p_apply;
    @(posedge clk_i) disable iff (rst_i)
    s_reg.pwr_ctrl_en && csp_code_legal(s_reg.vcc_req, 1'b0) &&
    csp_code_ok(s_reg.vcc_req, 1'b0, s_reg.card_type)
    |=> vcc_sel_o == $past(s_reg.vcc_req);
  endproperty
  a_apply: assert property (p_apply)
    else $error("accepted supply request not applied");

  property p_apply_vpp;
    @(posedge clk_i) disable iff (rst_i)
    s_reg.pwr_ctrl_en && $past(s_reg.vpp_req) == 3'h1 &&
    s_reg.vpp_req == 3'h1
    |=> vpp_sel_o == 3'h1;
  endproperty
  a_apply_vpp: assert property (p_apply_vpp)
    else $error("12 V programming request not applied");

  // Retest reloads the card type and enables power control
  property p_retest;
    @(posedge clk_i) disable iff (rst_i)
    wr_type && wb_req_i.sel[1] && wb_req_i.dat[`CSP_RETEST_BIT]
    |=> s_reg.pwr_ctrl_en && s_reg.card_type == $past(card_type_i);
  endproperty
  a_retest: assert property (p_retest)
    else $error("retest did not reload card type");

  // A forced nonzero card type disables power control until a retest
  property p_forced_off;
    @(posedge clk_i) disable iff (rst_i)
    wr_type && wb_req_i.sel[1] && !wb_req_i.dat[`CSP_RETEST_BIT] &&
    (|wb_req_i.dat[`CSP_TYPE_LSB +: 4])
    |=> !s_reg.pwr_ctrl_en;
  endproperty
  a_forced_off: assert property (p_forced_off)
    else $error("forced card type left power control on");

  // Main scenarios
  c_refused: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(s_reg.refused));
  c_wake_hold: cover property (@(posedge clk_i) disable iff (rst_i)
    bus_reset_in_i && s_reg.wake_en && s_reg.vcc_req != 3'h0);
  c_powered: cover property (@(posedge clk_i) disable iff (rst_i)
    $changed(vcc_sel_o) && vcc_sel_o != 3'h0);

endmodule

// file: sim/csp_card_model.sv
// Model of the socket power switch and the inserted card.
// Assumes switch codes from the block and one clock with active high reset.
module csp_card_model
  import csp_pkg::*;
#(
  parameter logic [3:0] CARD_VOLTS = 4'h3
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Switch codes from the block
  input wire logic [2:0] vcc_sel_i,
  input wire logic [2:0] vpp_sel_i,
  // Card sense and misuse flag
  output logic [3:0] card_type_o,
  output logic bad_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // True when the card can take the rail that the code selects
  function automatic logic rail_ok(input logic [2:0] code, input logic pp);
    case (code)
      3'h0: rail_ok = 1'b1;
      3'h1: rail_ok = pp;
      3'h2, 3'h3, 3'h4, 3'h5: rail_ok = CARD_VOLTS[code - 3'h2];
      default: rail_ok = 1'b0;
    endcase
  endfunction

  // Card reports the voltages it accepts
  assign card_type_o = CARD_VOLTS;

  // Sticky flag for any rail that would harm the card
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bad_o <= 1'b0;
    else if (!rail_ok(vcc_sel_i, 1'b0) || !rail_ok(vpp_sel_i, 1'b1))
      bad_o <= 1'b1;
  end
endmodule

// file: sim/test_csp_socket_power.sv
// Self-checking bench for the socket power control block.
// Assumes the block's Wishbone slave, a 10 MHz clock and the card model.
`include "csp_regs.svh"
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module test_csp_socket_power
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTRL = `CSP_SOCKET_CTRL_ADDR;
  localparam logic [7:0] CTYP = `CSP_CARD_TYPE_ADDR;
  logic clk, rst, ack, bus_rst, idle, prep, stop_ok, bad;
  logic [31:0] rdata, d;
  logic [3:0] ctype;
  logic [2:0] vcc_sel, vpp_sel;
  csp_wb_req_type req;
  int err_total = 0;
  int compares = 0;
  logic [2:0] vexp [0:7] = '{3'h0, 3'h0, 3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [2:0] pexp [0:7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0};

  csp_socket_power #(.IDLE_CLOCKS(8)) uut (
    .clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_ack_o(ack),
    .wb_dat_o(rdata), .bus_reset_in_i(bus_rst), .card_type_i(ctype),
    .socket_idle_i(idle), .pci_stop_prep_i(prep), .vcc_sel_o(vcc_sel),
    .vpp_sel_o(vpp_sel), .card_clock_stop_ok_o(stop_ok));

  csp_card_model #(.CARD_VOLTS(4'h3)) card (
    .clk_i(clk), .rst_i(rst), .vcc_sel_i(vcc_sel), .vpp_sel_i(vpp_sel),
    .card_type_o(ctype), .bad_o(bad));

  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: wd};
    // Only the watchdog ends a wait for ack
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd = rdata;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, s, wd, x);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 4'hF, 32'h0, d);
  endtask

  // Let the switch outputs follow the stored request
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Idle run: low after seven idle cycles, high from the eighth on
  task automatic stop_run;
    @(posedge clk);
    idle <= 1'b1;
    repeat (7) @(posedge clk);
    #1 `CHK(stop_ok, 1'b0)
    @(posedge clk);
    #1 `CHK(stop_ok, 1'b1)
    @(posedge clk);
    idle <= 1'b0;
    @(posedge clk);
    #1 `CHK(stop_ok, 1'b0)
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog against a hung handshake
  initial
  begin
    #(3000 * 100);
    err_total++;
    conclude;
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    bus_rst = 1'b0;
    idle = 1'b0;
    prep = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL);
    `CHK(d, 32'h0000_0400)
    rd(CTYP);
    `CHK(d, 32'h0000_0004)
    rd(8'h20);
    `CHK(d, 32'h0000_0000)
    wr(CTRL, 4'hF, 32'hFFFF_FFFF);
    rd(CTRL);
    `CHK(d, 32'h0000_04F7)
    `CHK({vcc_sel, vpp_sel}, 6'h00)
    wr(CTRL, 4'h1, 32'h0);
    wr(CTYP, 4'h2, 32'h0000_1400);
    rd(CTYP);
    `CHK(d, 32'h0000_1400)
    wr(CTYP, 4'h2, 32'h0000_4000);
    rd(CTYP);
    `CHK(d, 32'h0000_0C04)
    // Every supply and programming code, powering off in between
    for (int c = 0; c < 8; c++)
    begin
      wr(CTRL, 4'h1, {25'h0, c[2:0], 4'h0});
      settle;
      `CHK(vcc_sel, vexp[c])
      wr(CTRL, 4'h1, 32'h0);
      wr(CTRL, 4'h1, {29'h0, c[2:0]});
      settle;
      `CHK(vpp_sel, pexp[c])
      wr(CTRL, 4'h1, 32'h0);
    end
    wr(CTYP, 4'h1, 32'h2);
    wr(CTRL, 4'h1, 32'h40);
    settle;
    rd(CTYP);
    `CHK(d[1], 1'b1)
    wr(CTRL, 4'h1, 32'h0);
    wr(CTYP, 4'h1, 32'h2);
    rd(CTYP);
    `CHK(d[1], 1'b0)
    wr(CTRL, 4'h1, 32'h20);
    wr(CTRL, 4'h1, 32'h60);
    settle;
    `CHK(vcc_sel, 3'h2)
    wr(CTRL, 4'h1, 32'hA1);
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    rd(CTRL);
    `CHK(d, 32'h0000_0480)
    wr(CTYP, 4'h1, 32'h1);
    wr(CTRL, 4'h1, 32'h23);
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    rd(CTRL);
    `CHK(d, 32'h0000_0423)
    `CHK(bad, 1'b0)
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL);
    `CHK(d, 32'h0000_0400)
    `CHK({vcc_sel, vpp_sel}, 6'h00)
    // Clock stop under both policies
    wr(CTRL, 4'h1, 32'h80);
    stop_run;
    wr(CTRL, 4'h1, 32'h0);
    @(posedge clk);
    idle <= 1'b1;
    repeat (12) @(posedge clk);
    #1 `CHK(stop_ok, 1'b0)
    @(posedge clk);
    idle <= 1'b0;
    prep <= 1'b1;
    stop_run;
    `CHK(bad, 1'b0)
    conclude;
  end
endmodule
